// ===== ssom_top.sv
`timescale 1ns/10ps
// Overview of operation
// - not ready: enable request ignored, drive stays disabled, motor unexcited
// - ready needs no fault, supply normal, torque-off and halt untriggered
// - code 23 closes while ready; code 24 closes while not ready
// - code 7 closes while enabled; code 8 closes while disabled
// - while running, flag follow error when position error exceeds threshold
// - code 11 closes on follow error; code 12 inverts
// - limit output when motor meets limit in its running direction
// - code 27 closes on forward limit; code 28 inverts
// - code 29 closes on reverse limit; code 30 inverts
// - absolute mode: input switch or soft limit triggers limit output
// - each of six outputs has its own function select
// - ready may persist about one second after mains removal
// - mains absent: ready deasserted and low-voltage warning raised
// - mains lost while enabled: warning, fault, or position alarm if moving
module ssom_top
   import ssom_pkg::*;
#(
   parameter int HOLD_CYCLES = READY_HOLD_CYC
) (
   // clock and reset
   input  wire logic                        i_clock,
   input  wire logic                        i_nrst,
   // pin inputs
   input  wire logic                        i_enable_request,
   input  wire logic                        i_mains_ok,
   input  wire logic                        i_safe_torque_off,
   input  wire logic                        i_emergency_halt,
   input  wire logic                        i_fwd_limit_switch,
   input  wire logic                        i_rev_limit_switch,
   // internal drive state, same clock
   input  wire logic                        i_fault,
   input  wire logic                        i_moving,
   input  wire logic                        i_dir_reverse,
   input  wire logic                        i_absolute_mode,
   input  wire logic signed [POS_WIDTH-1:0] i_actual_pos,
   input  wire logic signed [POS_WIDTH-1:0] i_command_pos,
   // settings
   input  wire logic        [POS_WIDTH-1:0] i_follow_error_threshold,
   input  wire logic signed [POS_WIDTH-1:0] i_soft_pos_limit,
   input  wire logic signed [POS_WIDTH-1:0] i_soft_neg_limit,
   input  wire logic        [7:0]           i_output_function_select [NUM_OUTPUTS],
   // status
   output logic                             o_ready,
   output logic                             o_enabled,
   output logic                             o_follow_error,
   output logic                             o_fwd_limit,
   output logic                             o_rev_limit,
   output logic                             o_low_voltage_warn,
   output logic                             o_undervolt_warn,
   output logic                             o_low_voltage_fault,
   output logic                             o_pos_error_alarm,
   // digital outputs, high means closed
   output logic             [NUM_OUTPUTS-1:0] o_digital_outputs
);
   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [6:0] pins_sync;
   logic       sync_armed;
   logic       enable_req_s;
   logic       mains_ok_s;
   logic       sto_s;
   logic       halt_s;
   logic       fwd_sw_s;
   logic       rev_sw_s;

   // constant high bit marks when the flops hold real pin levels
   ssom_sync #(.WIDTH(7)) u_sync (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .i_async ({1'b1, i_enable_request, i_mains_ok, i_safe_torque_off,
                 i_emergency_halt, i_fwd_limit_switch, i_rev_limit_switch}),
      .o_sync  (pins_sync)
   );

   assign {sync_armed, enable_req_s, mains_ok_s, sto_s, halt_s, fwd_sw_s, rev_sw_s} = pins_sync;

   // ************************************************************
   // helpers
   // ************************************************************
   // magnitude of a signed difference
   function automatic logic [POS_WIDTH:0] ssom_abs_diff(
      input logic signed [POS_WIDTH-1:0] a,
      input logic signed [POS_WIDTH-1:0] b
   );
      logic signed [POS_WIDTH:0] d;
      d = {a[POS_WIDTH-1], a} - {b[POS_WIDTH-1], b};
      ssom_abs_diff = d[POS_WIDTH] ? (POS_WIDTH+1)'(-d) : d;
   endfunction : ssom_abs_diff

   // ************************************************************
   // ready with mains discharge hold
   // ************************************************************
   logic        ready;
   logic        next_ready;
   logic [31:0] hold_cnt;
   logic [31:0] next_hold_cnt;
   logic        base_ok;

   // ready needs all conditions; mains drop is held off by the bulk capacitor
   assign base_ok = !i_fault && !sto_s && !halt_s;

   always_comb begin
      next_ready    = ready;
      next_hold_cnt = hold_cnt;
      if (!base_ok) begin
         next_ready    = 1'b0;
         next_hold_cnt = '0;
      end else if (mains_ok_s) begin
         next_ready    = 1'b1;
         next_hold_cnt = '0;
      end else if (ready && hold_cnt < 32'(HOLD_CYCLES - 1)) begin
         next_hold_cnt = hold_cnt + 32'h1;
      end else begin
         next_ready    = 1'b0;
         next_hold_cnt = '0;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         ready    <= 1'b0;
         hold_cnt <= '0;
      end else begin
         ready    <= next_ready;
         hold_cnt <= next_hold_cnt;
      end
   end

   // ************************************************************
   // enable state and status flags
   // ************************************************************
   logic enabled;
   logic next_enabled;
   logic follow_err;
   logic next_follow_err;
   logic fwd_lim;
   logic next_fwd_lim;
   logic rev_lim;
   logic next_rev_lim;
   logic lv_warn;
   logic next_lv_warn;
   logic uv_warn;
   logic next_uv_warn;
   logic lv_fault;
   logic next_lv_fault;
   logic pos_alarm;
   logic next_pos_alarm;
   logic fwd_hit;
   logic rev_hit;

   // limit sources: switches, plus soft limits in absolute mode
   assign fwd_hit = fwd_sw_s ||
                    (i_absolute_mode && i_actual_pos >= i_soft_pos_limit);
   assign rev_hit = rev_sw_s ||
                    (i_absolute_mode && i_actual_pos <= i_soft_neg_limit);

   always_comb begin
      // enable only granted while ready
      next_enabled    = enable_req_s && ready;
      // position error compare while running
      next_follow_err = i_moving &&
                        (ssom_abs_diff(i_actual_pos, i_command_pos) >
                         {1'b0, i_follow_error_threshold});
      // limit only in the running direction
      next_fwd_lim    = i_moving && !i_dir_reverse && fwd_hit;
      next_rev_lim    = i_moving && i_dir_reverse && rev_hit;
      // mains absent warning
      // sync flops reset low: no false warning until they are filled
      next_lv_warn    = !mains_ok_s && sync_armed;
      // mains loss while enabled
      next_uv_warn    = enabled && !mains_ok_s;
      next_lv_fault   = enabled && !mains_ok_s && !ready;
      next_pos_alarm  = enabled && !mains_ok_s && i_moving;
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         enabled    <= 1'b0;
         follow_err <= 1'b0;
         fwd_lim    <= 1'b0;
         rev_lim    <= 1'b0;
         lv_warn    <= 1'b0;
         uv_warn    <= 1'b0;
         lv_fault   <= 1'b0;
         pos_alarm  <= 1'b0;
      end else begin
         enabled    <= next_enabled;
         follow_err <= next_follow_err;
         fwd_lim    <= next_fwd_lim;
         rev_lim    <= next_rev_lim;
         lv_warn    <= next_lv_warn;
         uv_warn    <= next_uv_warn;
         lv_fault   <= next_lv_fault;
         pos_alarm  <= next_pos_alarm;
      end
   end

   // ************************************************************
   // output mapping
   // ************************************************************
   logic [NUM_OUTPUTS-1:0] closed;
   logic [NUM_OUTPUTS-1:0] outs;
   logic [NUM_OUTPUTS-1:0] next_outs;

   // one selector per output
   for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : g_out
      ssom_mux u_mux (
         .i_func       (i_output_function_select[g]),
         .i_ready      (ready),
         .i_enabled    (enabled),
         .i_follow_err (follow_err),
         .i_fwd_limit  (fwd_lim),
         .i_rev_limit  (rev_lim),
         .o_closed     (closed[g])
      );
   end

   // re-evaluated every cycle
   always_comb begin
      next_outs = closed;
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         outs <= '0;
      end else begin
         outs <= next_outs;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign o_ready             = ready;
   assign o_enabled           = enabled;
   assign o_follow_error      = follow_err;
   assign o_fwd_limit         = fwd_lim;
   assign o_rev_limit         = rev_lim;
   assign o_low_voltage_warn  = lv_warn;
   assign o_undervolt_warn    = uv_warn;
   assign o_low_voltage_fault = lv_fault;
   assign o_pos_error_alarm   = pos_alarm;
   assign o_digital_outputs   = outs;
endmodule : ssom_top

// ===== ssom_pkg.sv
package ssom_pkg;
   // ************************************************************
   // output function codes
   // ************************************************************
   localparam logic [7:0] FC_ENABLED_CLOSE  = 8'h07;
   localparam logic [7:0] FC_ENABLED_OPEN   = 8'h08;
   localparam logic [7:0] FC_FOLLOW_CLOSE   = 8'h0b;
   localparam logic [7:0] FC_FOLLOW_OPEN    = 8'h0c;
   localparam logic [7:0] FC_READY_CLOSE    = 8'h17;
   localparam logic [7:0] FC_READY_OPEN     = 8'h18;
   localparam logic [7:0] FC_FWD_CLOSE      = 8'h1b;
   localparam logic [7:0] FC_FWD_OPEN       = 8'h1c;
   localparam logic [7:0] FC_REV_CLOSE      = 8'h1d;
   localparam logic [7:0] FC_REV_OPEN       = 8'h1e;

   // ************************************************************
   // sizes and timing
   // ************************************************************
   localparam int          NUM_OUTPUTS      = 6;
   localparam int          POS_WIDTH        = 32;
   localparam int          CLOCK_HZ         = 50_000_000;
   localparam int          READY_HOLD_MS    = 1000;
   localparam int          READY_HOLD_CYC   = CLOCK_HZ / 1000 * READY_HOLD_MS;
   localparam logic [7:0]  FUNC_RESET       = 8'h00;
endpackage : ssom_pkg

// ===== ssom_sync.sv
`timescale 1ns/10ps
// ************************************************************
// two flop synchroniser for pin inputs
// ************************************************************
module ssom_sync
   import ssom_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_nrst,
   // data
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_stage2;

   // next values
   always_comb begin
      next_stage1 = i_async;
      next_stage2 = stage1;
   end

   // registers
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
      end
   end

   assign o_sync = stage2;
endmodule : ssom_sync

// ===== ssom_mux.sv
`timescale 1ns/10ps
// ************************************************************
// one digital output: function select and polarity
// ************************************************************
module ssom_mux
   import ssom_pkg::*;
(
   // function select
   input  wire logic [7:0] i_func,
   // drive states
   input  wire logic       i_ready,
   input  wire logic       i_enabled,
   input  wire logic       i_follow_err,
   input  wire logic       i_fwd_limit,
   input  wire logic       i_rev_limit,
   // closed level
   output logic            o_closed
);
   // recomputed every cycle, no latching
   always_comb begin
      if (i_func == FC_READY_CLOSE) begin
         o_closed = i_ready;
      end else if (i_func == FC_READY_OPEN) begin
         o_closed = !i_ready;
      end else if (i_func == FC_ENABLED_CLOSE) begin
         o_closed = i_enabled;
      end else if (i_func == FC_ENABLED_OPEN) begin
         o_closed = !i_enabled;
      end else if (i_func == FC_FOLLOW_CLOSE) begin
         o_closed = i_follow_err;
      end else if (i_func == FC_FOLLOW_OPEN) begin
         o_closed = !i_follow_err;
      end else if (i_func == FC_FWD_CLOSE) begin
         o_closed = i_fwd_limit;
      end else if (i_func == FC_FWD_OPEN) begin
         o_closed = !i_fwd_limit;
      end else if (i_func == FC_REV_CLOSE) begin
         o_closed = i_rev_limit;
      end else if (i_func == FC_REV_OPEN) begin
         o_closed = !i_rev_limit;
      end else begin
         o_closed = 1'b0;                 // unassigned code: open
      end
   end
endmodule : ssom_mux

// ===== ssom_top_asserts.sv
`timescale 1ns/10ps
// ************************************************************
// status output checker
// ************************************************************
module ssom_chk
   import ssom_pkg::*;
#(
   parameter int HOLD_CYCLES = READY_HOLD_CYC
) (
   // clock and reset
   input wire logic             i_clock,
   input wire logic             i_nrst,
   // drive state and settings
   input wire logic             i_mains_ok,
   input wire logic             i_fault,
   input wire logic             i_moving,
   input wire logic [7:0]       i_output_function_select [NUM_OUTPUTS],
   // status
   input wire logic             o_ready,
   input wire logic             o_enabled,
   input wire logic             o_fwd_limit,
   input wire logic             o_rev_limit,
   input wire logic             o_low_voltage_warn,
   input wire logic [NUM_OUTPUTS-1:0] o_digital_outputs
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   // mains held absent past the pin sync
   sequence s_mains_gone;
      (!i_mains_ok) [*5];
   endsequence
   a_enable_needs_ready: assert property (o_enabled |-> $past(o_ready))
      else $error("enabled without ready");
   a_fault_drops_ready: assert property (i_fault |=> !o_ready)
      else $error("ready kept during fault");
   a_idle_no_limit: assert property (!i_moving |=> !o_fwd_limit && !o_rev_limit)
      else $error("limit while idle");
   a_mains_warn: assert property (s_mains_gone |-> o_low_voltage_warn)
      else $error("no low voltage warning");
   a_ready_close: assert property (i_output_function_select[0] == FC_READY_CLOSE
      |=> o_digital_outputs[0] == $past(o_ready)) else $error("ready close level");
   a_ready_open: assert property (i_output_function_select[1] == FC_READY_OPEN
      |=> o_digital_outputs[1] != $past(o_ready)) else $error("ready open level");
   a_enab_close: assert property (i_output_function_select[2] == FC_ENABLED_CLOSE
      |=> o_digital_outputs[2] == $past(o_enabled)) else $error("enabled close level");
   a_enab_open: assert property (i_output_function_select[3] == FC_ENABLED_OPEN
      |=> o_digital_outputs[3] != $past(o_enabled)) else $error("enabled open level");
   a_unknown_open: assert property (i_output_function_select[5] == FUNC_RESET
      |=> !o_digital_outputs[5]) else $error("unused code closed");
endmodule : ssom_chk

bind ssom_top ssom_chk #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
   .i_clock, .i_nrst, .i_mains_ok, .i_fault, .i_moving, .i_output_function_select,
   .o_ready, .o_enabled, .o_fwd_limit, .o_rev_limit, .o_low_voltage_warn,
   .o_digital_outputs);

// ===== ssom_host.sv
`timescale 1ns/10ps
// ************************************************************
// host controller reading the output contacts
// ************************************************************
module ssom_host (
   // clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_nrst,
   // contacts, high means closed
   input  wire logic [5:0] i_outputs,
   output logic      [5:0] o_seen
);
   logic [5:0] next_seen;
   // take contact levels each cycle
   always_comb begin
      next_seen = i_outputs;
   end
   // register captured levels
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_seen <= 6'h00;
      end else begin
         o_seen <= next_seen;
      end
   end
endmodule : ssom_host

// ===== ssom_tb_top.sv
`timescale 1ns/10ps
module ssom_tb_top
   import ssom_pkg::*;
();
   localparam int HOLD = 10;
   logic clk, nrst, en_req, mains, safe_torque_off, halt, fsw, rsw, fault, mv, dir, ab;
   logic signed [POS_WIDTH-1:0] act, cmd, spos, sneg;
   logic        [POS_WIDTH-1:0] thr;
   logic        [7:0]           sel [NUM_OUTPUTS];
   logic rdy, ena, fe, fl, rl, lvw, uvw, lvf, pea;
   logic [NUM_OUTPUTS-1:0] dout, seen;
   int mismatches, n_checks;
   // design and host
   ssom_top #(.HOLD_CYCLES(HOLD)) dut (.i_clock(clk), .i_nrst(nrst),
      .i_enable_request(en_req), .i_mains_ok(mains), .i_safe_torque_off(safe_torque_off),
      .i_emergency_halt(halt), .i_fwd_limit_switch(fsw), .i_rev_limit_switch(rsw),
      .i_fault(fault), .i_moving(mv), .i_dir_reverse(dir), .i_absolute_mode(ab),
      .i_actual_pos(act), .i_command_pos(cmd), .i_follow_error_threshold(thr),
      .i_soft_pos_limit(spos), .i_soft_neg_limit(sneg), .i_output_function_select(sel),
      .o_ready(rdy), .o_enabled(ena), .o_follow_error(fe), .o_fwd_limit(fl),
      .o_rev_limit(rl), .o_low_voltage_warn(lvw), .o_undervolt_warn(uvw),
      .o_low_voltage_fault(lvf), .o_pos_error_alarm(pea), .o_digital_outputs(dout));
   ssom_host u_host (.i_clock(clk), .i_nrst(nrst), .i_outputs(dout), .o_seen(seen));
   // clock
   always #10 clk = ~clk;
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic cmp(input string what, input logic [5:0] exp, input logic [5:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   task automatic t_gate();
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         safe_torque_off <= (i == 0);
         halt <= (i == 1);
         fault <= (i == 2);
         tick(8);
         cmp("ready", 6'h00, 6'(rdy));
         cmp("enabled", 6'h00, 6'(ena));
         cmp("contacts", 6'h2a, seen);
         @(posedge clk);
         {safe_torque_off, halt, fault} <= 3'h0;
         tick(8);
         cmp("enabled", 6'h01, 6'(ena));
         cmp("contacts", 6'h25, seen);
      end
      $display("t_gate done");
   endtask : t_gate
   task automatic fe_case(input logic signed [31:0] a, c, input logic m, e);
      @(posedge clk);
      {act, cmd, mv} <= {a, c, m};
      tick(4);
      cmp("follow", 6'(e), 6'(fe));
      cmp("follow contacts", {4'h0, !e, e}, {4'h0, seen[1:0]});
   endtask : fe_case
   task automatic lim_case(input logic sf, sr, m, d, a, input logic signed [31:0] p,
                           input logic ef, er);
      @(posedge clk);
      {fsw, rsw, mv, dir, ab, act, cmd} <= {sf, sr, m, d, a, p, p};
      tick(7);
      cmp("limits", {4'h0, ef, er}, {4'h0, fl, rl});
      cmp("limit contacts", {!ef, ef, !er, er, 2'h0}, {seen[5:2], 2'h0});
   endtask : lim_case
   task automatic t_mains();
      @(posedge clk);
      mains <= 1'b0;
      mv <= 1'b1;
      tick(6);
      cmp("warnings", 6'h07, {2'h0, lvf, lvw, uvw, pea});
      cmp("ready held", 6'h01, 6'(rdy));
      tick(HOLD - 5);
      cmp("ready hold end", 6'h01, 6'(rdy));
      tick(2);
      cmp("mains loss", 6'h0f, {rdy, ena, lvf, lvw, uvw, pea});
      tick(9);
      cmp("ready dropped", 6'h00, 6'(rdy));
      cmp("warn only", 6'h04, {2'h0, lvf, lvw, uvw, pea});
      @(posedge clk);
      mains <= 1'b1;
      tick(8);
      cmp("recovered", 6'h02, {4'h0, rdy, lvw});
      $display("t_mains done");
   endtask : t_mains
   // watchdog
   initial begin
      #40000;
      mismatches++;
      end_sim();
   end
   // main sequence
   initial begin
      {clk, nrst, en_req, safe_torque_off, halt, fsw, rsw, fault, mv, dir, ab} = 11'h000;
      {mains, act, cmd, thr, spos, sneg} = {1'b1, 32'h0, 32'h0, 32'h64, 32'h1388, -32'sd5000};
      sel = '{default: 8'h00};
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      tick(8);
      cmp("unused codes", 6'h00, seen);
      @(posedge clk);
      sel <= '{FC_READY_CLOSE, FC_READY_OPEN, FC_ENABLED_CLOSE, FC_ENABLED_OPEN,
               FC_FWD_CLOSE, FC_FWD_OPEN};
      en_req <= 1'b1;
      t_gate();
      @(posedge clk);
      sel[0] <= FC_FOLLOW_CLOSE;
      sel[1] <= FC_FOLLOW_OPEN;
      fe_case(1000, 900, 1'b1, 1'b0);
      fe_case(1001, 900, 1'b1, 1'b1);
      fe_case(900, 1001, 1'b1, 1'b1);
      fe_case(1001, 900, 1'b0, 1'b0);
      $display("follow done");
      @(posedge clk);
      sel[2] <= FC_REV_CLOSE;
      sel[3] <= FC_REV_OPEN;
      lim_case(1, 0, 1, 0, 0, 0, 1, 0);
      lim_case(1, 0, 1, 1, 0, 0, 0, 0);
      lim_case(0, 1, 1, 1, 0, 0, 0, 1);
      lim_case(0, 0, 1, 0, 1, 5000, 1, 0);
      lim_case(0, 0, 1, 1, 1, -5000, 0, 1);
      lim_case(0, 0, 1, 0, 0, 5000, 0, 0);
      lim_case(1, 1, 0, 0, 1, 9000, 0, 0);
      $display("limits done");
      t_mains();
      end_sim();
   end
endmodule : ssom_tb_top
